// ### hdl/jpeg_host_fifo_control.sv
// Purpose: host side mode, fifo and line buffer control
// Assumes: avalon-mm slave, word address equals register index
// Notes: reads take one wait cycle, writes none
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "jhf_cfg.svh"
module jpeg_host_fifo_control #(
	parameter int FIFO_AW = 14
) (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic [15:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [15:0] AVS_WRITEDATA_I,
	input wire logic [1:0] AVS_BYTEENABLE_I,
	output logic [15:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	input wire logic CDC_PUSH_I,
	input wire logic [31:0] CDC_PDATA_I,
	output logic CDC_PREADY_O,
	input wire logic CDC_POP_I,
	output logic [31:0] CDC_CDATA_O,
	output logic CDC_CVALID_O,
	input wire logic CDC_DONE_I,
	input wire logic MARKER_I,
	input wire logic LB_EMPTY_I,
	output logic RUN_O,
	output logic DECODE_O,
	output logic HALT_O,
	output logic CAP_RUN_O,
	output logic YUV420_O,
	output logic MOD_EN_O,
	output logic SRST_O,
	output logic CRST_O,
	output logic LB_WE_O,
	output logic [15:0] LB_WDATA_O
);
	localparam int FW = FIFO_AW + 1;
	localparam logic [15:0] PHYS = 16'(1 << FIFO_AW);
	localparam jhf_pkg::state_t STATE_RST = '{
		lb_empty: `LB_EMPTY_RST,
		st: jhf_pkg::ST_IDLE,
		default: '0
	};
	generate
		if (FIFO_AW < 1 || FIFO_AW > 14)
		begin : g_bad
			$error("jpeg_host_fifo_control: FIFO_AW out of range");
		end
	endgenerate

	// ==========================================================
	// helpers
	function automatic jhf_pkg::mode_t mode_of(input logic [2:0] m);
		case (m)
			`MODE_CAP422, `MODE_CAP420: mode_of = jhf_pkg::MD_CAPTURE;
			`MODE_DSP422, `MODE_DSP420: mode_of = jhf_pkg::MD_DISPLAY;
			default: mode_of = jhf_pkg::MD_CODEC;
		endcase
	endfunction

	function automatic logic [15:0] lanes(input logic [1:0] be);
		lanes = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	// ==========================================================
	// reset release
	logic [1:0] rst_s;
	logic rst_n;
	always_ff @(posedge CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
		begin
			rst_s <= 2'h0;
		end
		else
		begin
			rst_s <= {rst_s[0], 1'b1};
		end
	end
	assign rst_n = rst_s[1];

	// ==========================================================
	// fifo
	jhf_pkg::state_t q;
	jhf_pkg::state_t n;
	logic fifo_clr;
	logic fifo_push;
	logic fifo_pop;
	logic [31:0] fifo_wdata;
	logic [31:0] f_head;
	logic [FW-1:0] f_cnt;
	logic f_full;
	logic f_empty;
	logic [15:0] cap_req;
	logic [FW-1:0] cap;
	logic [FW-1:0] thr_lvl;
	jhf_pkg::mode_t md;
	logic run;
	logic host_rd_ok;
	logic host_wr_ok;
	logic cdc_ok;
	logic [15:0] m;
	logic [15:0] wd;
	logic [15:0] reg_val;
	logic [31:0] fsz;

	// capacity: (size + 1) x 4K bytes, capped at the physical depth
	assign cap_req = 16'({12'h000, q.fsize} + 16'h0001) << `FIFO_UNIT_SHIFT;
	assign cap = FW'((cap_req > PHYS) ? PHYS : cap_req);
	// threshold 00..11: 1/8, 1/4, 1/2, whole capacity
	assign thr_lvl = cap >> (2'h3 - q.thr);

	jhf_store #(
		.W(32),
		.AW(FIFO_AW)
	) u_store (
		.clk_i(CLK_I),
		.rst_n_i(rst_n),
		.clr_i(fifo_clr),
		.cap_i(cap),
		.push_i(fifo_push),
		.wdata_i(fifo_wdata),
		.pop_i(fifo_pop),
		.head_o(f_head),
		.count_o(f_cnt),
		.full_o(f_full),
		.empty_o(f_empty)
	);

	assign md = mode_of(q.mode);
	assign run = q.st == jhf_pkg::ST_RUN;
	assign fsz = {q.fsz_hi, q.fsz_lo};
	// host port valid only while an operation runs
	assign host_rd_ok = q.mod_en && run && !q.dec_sel &&
		md != jhf_pkg::MD_DISPLAY;
	assign host_wr_ok = q.mod_en && run && q.dec_sel &&
		md == jhf_pkg::MD_CODEC;
	assign cdc_ok = q.mod_en && run && !q.dec_sel &&
		(md == jhf_pkg::MD_CODEC ||
		(md == jhf_pkg::MD_CAPTURE && q.cap_on));

	// ==========================================================
	// register read mux
	always_comb
	begin
		reg_val = 16'h0000;
		case (AVS_ADDRESS_I)
			`R_MOD_CTRL: reg_val = {12'h000, q.mode, q.mod_en};
			`R_MOD_STAT: reg_val = q.stat;
			`R_INT_CTRL: reg_val = q.int_en;
			`R_CAP_CTRL: reg_val = {15'h0000, q.cap_on};
			`R_FIFO_CTRL: reg_val = {10'h000, q.thr, 4'h0};
			`R_FIFO_SIZE: reg_val = {12'h000, q.fsize};
			`R_FIFO_PORT:
			begin
				if (host_rd_ok && !f_empty)
				begin
					reg_val = q.rd_half ? f_head[31:16] : f_head[15:0];
				end
			end
			`R_FIFO_CNT: reg_val = 16'(f_cnt);
			`R_FSZ_LO: reg_val = q.fsz_lo;
			`R_FSZ_HI: reg_val = q.fsz_hi;
			`R_LB_STAT: reg_val = {15'h0000, q.lb_empty};
			`R_LB_CTRL: reg_val = {15'h0000, q.lb_ien};
			`R_OP_SEL: reg_val = {13'h0000, q.dec_sel, 2'h0};
			`R_OP_STAT: reg_val = {15'h0000, run};
			default: reg_val = 16'h0000;
		endcase
	end

	// ==========================================================
	// next state
	always_comb
	begin
		n = q;
		fifo_clr = 1'b0;
		fifo_push = 1'b0;
		fifo_pop = 1'b0;
		fifo_wdata = CDC_PDATA_I;
		m = lanes(AVS_BYTEENABLE_I);
		wd = (reg_val & ~m) | (AVS_WRITEDATA_I & m);
		n.rd_done = 1'b0;
		n.lb_we = 1'b0;
		n.srst = 1'b0;
		n.crst = 1'b0;
		if (AVS_READ_I && !q.rd_done)
		begin
			n.rd_done = 1'b1;
			n.rdata = reg_val;
			if (AVS_ADDRESS_I == `R_FIFO_PORT && host_rd_ok && !f_empty)
			begin
				n.rd_half = !q.rd_half;
				fifo_pop = q.rd_half;
			end
		end
		if (AVS_WRITE_I)
		begin
			case (AVS_ADDRESS_I)
				`R_MOD_CTRL:
				begin
					n.mod_en = wd[`B_MOD_EN];
					n.mode = wd[3:1];
					if (wd[`B_SRST])
					begin
						n.srst = 1'b1;
						n.st = jhf_pkg::ST_IDLE;
						n.stat = 16'h0000;
						n.eoi = 1'b0;
						n.wr_half = 1'b0;
						n.rd_half = 1'b0;
						n.cap_on = 1'b0;
						n.lb_empty = `LB_EMPTY_RST;
						fifo_clr = 1'b1;
					end
				end
				`R_MOD_STAT: n.stat = q.stat & ~(AVS_WRITEDATA_I & m);
				`R_INT_CTRL: n.int_en = wd;
				`R_CAP_CTRL:
				begin
					n.cap_on = wd[`B_CAP_ON];
					// eoi marks a stopped capture
					if (run && md == jhf_pkg::MD_CAPTURE && !wd[`B_CAP_ON])
					begin
						n.eoi = 1'b1;
					end
				end
				`R_FIFO_CTRL:
				begin
					n.thr = wd[5:4];
					if (wd[`B_FIFO_CLR])
					begin
						fifo_clr = 1'b1;
						n.wr_half = 1'b0;
						n.rd_half = 1'b0;
					end
				end
				`R_FIFO_SIZE: n.fsize = wd[3:0];
				`R_FIFO_PORT:
				begin
					if (host_wr_ok)
					begin
						n.wr_half = !q.wr_half;
						if (!q.wr_half)
						begin
							n.wr_low = wd;
						end
						else if (!f_full)
						begin
							fifo_push = 1'b1;
							fifo_wdata = {wd, q.wr_low};
							n.wr_cnt = q.wr_cnt + 30'h00000001;
							if ({q.wr_cnt + 30'h00000001, 2'h0} >= fsz)
							begin
								n.eoi = 1'b1;
							end
						end
					end
				end
				`R_FSZ_LO: n.fsz_lo = wd;
				`R_FSZ_HI: n.fsz_hi = wd;
				`R_LB_STAT:
				begin
					if (AVS_WRITEDATA_I[`B_LB_EMPTY] && m[`B_LB_EMPTY])
					begin
						n.lb_empty = 1'b0;
					end
				end
				`R_LB_CTRL: n.lb_ien = wd[0];
				`R_LB_PORT:
				begin
					if (q.mod_en && md == jhf_pkg::MD_DISPLAY && q.lb_empty)
					begin
						n.lb_we = 1'b1;
						n.lb_wdata = wd;
					end
				end
				`R_OP_SEL: n.dec_sel = wd[`B_DEC_SEL];
				`R_CODEC_CTRL:
				begin
					if (wd[`B_CRST])
					begin
						n.crst = 1'b1;
						n.st = jhf_pkg::ST_IDLE;
						n.eoi = 1'b0;
						n.wr_half = 1'b0;
						n.rd_half = 1'b0;
					end
					else if (wd[`B_START])
					begin
						n.st = jhf_pkg::ST_RUN;
						n.wr_cnt = 30'h00000000;
						n.eoi = 1'b0;
						n.wr_half = 1'b0;
						n.rd_half = 1'b0;
					end
				end
				default:
				begin
				end
			endcase
		end
		// codec and capture side of the fifo
		if (cdc_ok && CDC_PUSH_I && !fifo_push)
		begin
			fifo_push = 1'b1;
			fifo_wdata = CDC_PDATA_I;
		end
		if (CDC_CVALID_O && CDC_POP_I)
		begin
			fifo_pop = 1'b1;
		end
		if (run && q.dec_sel && !q.eoi && n.eoi && q.int_en[`S_DEC_DONE])
		begin
			n.stat[`S_DEC_DONE] = 1'b1;
		end
		if (run && CDC_DONE_I && md == jhf_pkg::MD_CODEC)
		begin
			n.st = jhf_pkg::ST_IDLE;
			n.stat[`S_CODEC_DONE] = 1'b1;
		end
		if (run && md == jhf_pkg::MD_CAPTURE && q.eoi && !q.cap_on &&
			f_empty)
		begin
			n.st = jhf_pkg::ST_IDLE;
		end
		if (run && q.dec_sel && MARKER_I && q.int_en[`S_MARKER])
		begin
			n.stat[`S_MARKER] = 1'b1;
		end
		// set wins over a same-cycle clear
		if (f_empty)
		begin
			n.stat[`S_EMPTY] = 1'b1;
		end
		if (f_full)
		begin
			n.stat[`S_FULL] = 1'b1;
		end
		if (f_cnt >= thr_lvl)
		begin
			n.stat[`S_THR] = 1'b1;
		end
		if (LB_EMPTY_I)
		begin
			n.lb_empty = 1'b1;
		end
	end

	always_ff @(posedge CLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= STATE_RST;
		end
		else
		begin
			q <= n;
		end
	end

	// ==========================================================
	// outputs
	assign AVS_READDATA_O = q.rdata;
	assign AVS_WAITREQUEST_O = AVS_READ_I && !q.rd_done;
	assign CDC_PREADY_O = cdc_ok && !f_full;
	assign CDC_CDATA_O = f_head;
	assign CDC_CVALID_O = q.mod_en && run && q.dec_sel && !f_empty &&
		!q.stat[`S_MARKER];
	assign RUN_O = run;
	assign DECODE_O = q.dec_sel;
	assign HALT_O = run && q.dec_sel && q.stat[`S_MARKER];
	assign CAP_RUN_O = q.mod_en && run && md == jhf_pkg::MD_CAPTURE &&
		q.cap_on;
	assign YUV420_O = q.mode[2];
	assign MOD_EN_O = q.mod_en;
	assign SRST_O = q.srst;
	assign CRST_O = q.crst;
	assign LB_WE_O = q.lb_we;
	assign LB_WDATA_O = q.lb_wdata;
endmodule // jpeg_host_fifo_control
`default_nettype wire

// ### hdl/jhf_cfg.svh
// Purpose: register map, field positions and reset values
// Assumes: 16-bit registers, one per avalon word, index = printed offset
// Notes: definitions only
//
// Behaviour
// - mode 011/111 captures raw yuv via fifo
// - mode 001/101 sends host pixels to line buffer
// - write 81h enables module and soft resets
// - fifo capacity is (size field plus one) times 4K, capped at the physical depth
// - fifo control bit2 empties, bits5-4 set threshold
// - writing FFFFh to module status clears all flags except those set again in the same cycle
// - operation select bit2 picks decode, else encode
// - codec bit7 resets, bit0 starts or arms capture
// - marker flag halts decode; host reads, clears it
// - enabled decode complete rises when image end written
// - operation status bit0 reads zero when idle
// - fifo accesses outside an operation are ignored
// - start/stop bit0 runs capture until cleared
// - line buffer written only while empty, then w1c
// - 16-bit port, two accesses per 32-bit entry
// - decode stays halted until marker flag cleared
`ifndef JHF_CFG_SVH
`define JHF_CFG_SVH
// register indices
`define R_MOD_CTRL 16'h0980
`define R_MOD_STAT 16'h0982
`define R_INT_CTRL 16'h0986
`define R_CAP_CTRL 16'h098A
`define R_FIFO_CTRL 16'h09A0
`define R_FIFO_SIZE 16'h09A4
`define R_FIFO_PORT 16'h09A6
`define R_FIFO_CNT 16'h09A8
`define R_FSZ_LO 16'h09B8
`define R_FSZ_HI 16'h09BA
`define R_LB_STAT 16'h09C0
`define R_LB_CTRL 16'h09C6
`define R_LB_PORT 16'h09E0
`define R_OP_SEL 16'h1000
`define R_CODEC_CTRL 16'h1002
`define R_OP_STAT 16'h1004
// field positions
`define B_MOD_EN 0
`define B_SRST 7
`define B_FIFO_CLR 2
`define B_DEC_SEL 2
`define B_CRST 7
`define B_START 0
`define B_CAP_ON 0
`define B_LB_EMPTY 0
`define S_CODEC_DONE 1
`define S_MARKER 4
`define S_DEC_DONE 5
`define S_EMPTY 8
`define S_FULL 9
`define S_THR 10
// mode field patterns, bits 3-1
`define MODE_CAP422 3'h3
`define MODE_CAP420 3'h7
`define MODE_DSP422 3'h1
`define MODE_DSP420 3'h5
// 4K bytes of fifo in 32-bit entries
`define FIFO_UNIT_SHIFT 10
`define LB_EMPTY_RST 1'h1
`endif

// ### hdl/jhf_pkg.sv
// Purpose: types of the host fifo control
// Assumes: nothing
// Notes: widths follow the 16-bit register port
package jhf_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN} run_t;
	typedef enum logic [1:0] {MD_CODEC, MD_CAPTURE, MD_DISPLAY} mode_t;
	typedef struct packed {
		logic rd_done;
		logic [15:0] rdata;
		logic mod_en;
		logic [2:0] mode;
		logic [15:0] stat;
		logic [15:0] int_en;
		logic cap_on;
		logic [1:0] thr;
		logic [3:0] fsize;
		logic [15:0] fsz_lo;
		logic [15:0] fsz_hi;
		logic lb_empty;
		logic lb_ien;
		logic dec_sel;
		run_t st;
		logic eoi;
		logic wr_half;
		logic [15:0] wr_low;
		logic rd_half;
		logic [29:0] wr_cnt;
		logic lb_we;
		logic [15:0] lb_wdata;
		logic srst;
		logic crst;
	} state_t;
endpackage

// ### hdl/jhf_store.sv
// Purpose: 32-bit entry fifo storage with programmable capacity
// Assumes: capacity never above the physical depth
// Notes: clear wins over push and pop
`timescale 1ns/1ns
`default_nettype none
module jhf_store #(
	parameter int W = 32,
	parameter int AW = 14
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	input wire logic [AW:0] cap_i,
	input wire logic push_i,
	input wire logic [W-1:0] wdata_i,
	input wire logic pop_i,
	output logic [W-1:0] head_o,
	output logic [AW:0] count_o,
	output logic full_o,
	output logic empty_o
);
	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} ptr_t;
	ptr_t q;
	ptr_t next_q;
	logic [W-1:0] mem [0:(1<<AW)-1];
	logic do_push;
	logic do_pop;
	generate
		if (W < 1 || AW < 1 || AW > 15)
		begin : g_bad
			$error("jhf_store: unsupported width or depth");
		end
	endgenerate
	assign full_o = q.cnt >= cap_i;
	assign empty_o = q.cnt == '0;
	assign head_o = mem[q.rp];
	assign count_o = q.cnt;
	assign do_push = push_i && !full_o && !clr_i;
	assign do_pop = pop_i && !empty_o && !clr_i;
	always_comb
	begin
		next_q = q;
		if (clr_i)
		begin
			next_q = '0;
		end
		else
		begin
			if (do_push)
			begin
				next_q.wp = q.wp + 1'b1;
			end
			if (do_pop)
			begin
				next_q.rp = q.rp + 1'b1;
			end
			next_q.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= next_q;
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (do_push)
		begin
			mem[q.wp] <= wdata_i;
		end
	end
endmodule // jhf_store
`default_nettype wire

// ### tb/jhf_checker.sv
// Purpose: port assertions of the host fifo control
// Assumes: sees top module ports only
// Notes: bound to every instance of the top module
`timescale 1ns/1ns
`default_nettype none
`include "jhf_cfg.svh"
module jhf_checker (
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic [15:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [15:0] AVS_WRITEDATA_I,
	input wire logic [1:0] AVS_BYTEENABLE_I,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic CDC_PREADY_O,
	input wire logic CDC_CVALID_O,
	input wire logic RUN_O,
	input wire logic DECODE_O,
	input wire logic HALT_O,
	input wire logic YUV420_O,
	input wire logic MOD_EN_O,
	input wire logic SRST_O,
	input wire logic CRST_O,
	input wire logic LB_WE_O,
	input wire logic [15:0] LB_WDATA_O
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RSTN_I);
	// ==========================================
	// bus steps
	sequence mod_wr;
		AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
			AVS_ADDRESS_I == `R_MOD_CTRL;
	endsequence
	sequence cdc_wr;
		AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
			AVS_ADDRESS_I == `R_CODEC_CTRL;
	endsequence
	sequence sel_wr;
		AVS_WRITE_I && AVS_BYTEENABLE_I[0] &&
			AVS_ADDRESS_I == `R_OP_SEL;
	endsequence
	// ==========================================
	// assertions
	a_read_one_wait: assert property (AVS_READ_I && AVS_WAITREQUEST_O
		|=> !AVS_WAITREQUEST_O) else $error("read wait not one cycle");
	a_write_no_wait: assert property (AVS_WRITE_I |-> !AVS_WAITREQUEST_O)
		else $error("write waited");
	a_mode_fields: assert property (mod_wr |=>
		MOD_EN_O == $past(AVS_WRITEDATA_I[0])
		&& YUV420_O == $past(AVS_WRITEDATA_I[3])) else $error("mode field");
	a_soft_reset: assert property (mod_wr ##0 AVS_WRITEDATA_I[7]
		##1 !(AVS_WRITE_I && AVS_ADDRESS_I == `R_MOD_CTRL
		&& AVS_WRITEDATA_I[7]) |-> SRST_O ##1 !SRST_O)
		else $error("soft reset pulse");
	a_codec_reset: assert property (cdc_wr ##0 AVS_WRITEDATA_I[7]
		|=> CRST_O && !RUN_O) else $error("codec reset");
	a_codec_start: assert property (cdc_wr ##0 (AVS_WRITEDATA_I[1:0] == 2'h1)
		##0 !AVS_WRITEDATA_I[7] ##0 MOD_EN_O |=> RUN_O)
		else $error("start lost");
	a_decode_sel: assert property (sel_wr |=>
		DECODE_O == $past(AVS_WRITEDATA_I[2])) else $error("decode select");
	a_idle_gates: assert property (!RUN_O |->
		!CDC_PREADY_O && !CDC_CVALID_O) else $error("fifo open while idle");
	a_halt_stops: assert property (HALT_O |-> !CDC_CVALID_O)
		else $error("pop offered while halted");
	a_lb_write: assert property (LB_WE_O |->
		$past(AVS_WRITE_I && AVS_ADDRESS_I == `R_LB_PORT)
		&& LB_WDATA_O == $past(AVS_WRITEDATA_I &
		{{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}}))
		else $error("lb write");
endmodule // jhf_checker
bind jpeg_host_fifo_control jhf_checker u_jhf_checker (
	.CLK_I(CLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
	.AVS_WRITEDATA_I(AVS_WRITEDATA_I),
	.AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.CDC_PREADY_O(CDC_PREADY_O), .CDC_CVALID_O(CDC_CVALID_O), .RUN_O(RUN_O),
	.DECODE_O(DECODE_O), .HALT_O(HALT_O), .YUV420_O(YUV420_O),
	.MOD_EN_O(MOD_EN_O), .SRST_O(SRST_O), .CRST_O(CRST_O),
	.LB_WE_O(LB_WE_O), .LB_WDATA_O(LB_WDATA_O));
`default_nettype wire

// ### tb/jhf_codec_model.sv
// Purpose: codec side stand-in, pushes and pops fifo entries
// Assumes: one entry per cycle at most, slow mode every other
// Notes: push data of entry k is A5000000h plus k
`timescale 1ns/1ns
`default_nettype none
module jhf_codec_model (
	input wire logic clk_i,
	input wire logic push_en_i,
	input wire logic pop_en_i,
	input wire logic slow_i,
	input wire logic pready_i,
	input wire logic cvalid_i,
	input wire logic [31:0] cdata_i,
	output logic push_o,
	output logic [31:0] pdata_o,
	output logic pop_o,
	output int acc_o
);
	logic [31:0] got[$];
	int acc_n;
	initial
	begin
		push_o = 1'b0;
		pop_o = 1'b0;
		pdata_o = 32'h0;
		acc_o = 0;
	end
	assign acc_n = acc_o + int'(push_o && pready_i);
	always @(posedge clk_i)
	begin
		push_o <= push_en_i && !(slow_i && push_o);
		pop_o <= pop_en_i && !(slow_i && pop_o);
		acc_o <= acc_n;
		// released data lines toggle
		pdata_o <= push_en_i ? 32'hA5000000 + 32'(acc_n) : ~pdata_o;
		if (pop_o && cvalid_i)
			got.push_back(cdata_i);
	end
endmodule // jhf_codec_model
`default_nettype wire

// ### tb/jpeg_host_fifo_control_tb.sv
// Purpose: self-checking bench of the host fifo control
// Assumes: fifo depth 2048 entries, size field 0 gives 1024
// Notes: random values from a fixed seed
`timescale 1ns/1ns
`default_nettype none
`include "jhf_cfg.svh"
module jpeg_host_fifo_control_tb;
	localparam int CAP = 1024;
	logic CLK_I, RSTN_I, AVS_READ_I, AVS_WRITE_I, push_en, pop_en, slow;
	logic [15:0] AVS_ADDRESS_I, AVS_WRITEDATA_I, AVS_READDATA_O, v, lo, hi;
	logic AVS_WAITREQUEST_O, CDC_PUSH_I, CDC_PREADY_O, CDC_POP_I;
	logic CDC_CVALID_O, RUN_O, DECODE_O, HALT_O, CAP_RUN_O, YUV420_O;
	logic MOD_EN_O, LB_WE_O;
	logic [31:0] CDC_PDATA_I, CDC_CDATA_O, exp_q[$];
	logic [15:0] LB_WDATA_O, d, lb_last;
	logic [2:0] evt, modes[4];
	int n_mismatch, check_count, n, t, p, na, thr, lb_cnt;
	jpeg_host_fifo_control #(.FIFO_AW(11)) u_jpeg_host_fifo_control (
		.CLK_I(CLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
		.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
		.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(2'h3),
		.AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
		.CDC_PUSH_I(CDC_PUSH_I), .CDC_PDATA_I(CDC_PDATA_I),
		.CDC_PREADY_O(CDC_PREADY_O), .CDC_POP_I(CDC_POP_I),
		.CDC_CDATA_O(CDC_CDATA_O), .CDC_CVALID_O(CDC_CVALID_O),
		.CDC_DONE_I(evt[0]), .MARKER_I(evt[1]), .LB_EMPTY_I(evt[2]),
		.RUN_O(RUN_O), .DECODE_O(DECODE_O), .HALT_O(HALT_O),
		.CAP_RUN_O(CAP_RUN_O), .YUV420_O(YUV420_O), .MOD_EN_O(MOD_EN_O),
		.SRST_O(), .CRST_O(), .LB_WE_O(LB_WE_O), .LB_WDATA_O(LB_WDATA_O));
	jhf_codec_model u_jhf_codec_model (.clk_i(CLK_I), .push_en_i(push_en),
		.pop_en_i(pop_en), .slow_i(slow), .pready_i(CDC_PREADY_O),
		.cvalid_i(CDC_CVALID_O), .cdata_i(CDC_CDATA_O), .push_o(CDC_PUSH_I),
		.pdata_o(CDC_PDATA_I), .pop_o(CDC_POP_I), .acc_o(na));
	// ==========================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] dd);
		@(posedge CLK_I);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= dd;
		AVS_WRITE_I <= 1'b1;
		do @(posedge CLK_I); while (AVS_WAITREQUEST_O !== 1'b0);
		AVS_WRITE_I <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] dd);
		@(posedge CLK_I);
		AVS_ADDRESS_I <= a;
		AVS_READ_I <= 1'b1;
		do @(posedge CLK_I); while (AVS_WAITREQUEST_O !== 1'b0);
		dd = AVS_READDATA_O;
		AVS_READ_I <= 1'b0;
	endtask
	task automatic rc(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] r;
		rd(a, r);
		chk(32'(r), 32'(e));
	endtask
	task automatic pulse(input int b);
		@(posedge CLK_I);
		evt[b] <= 1'b1;
		@(posedge CLK_I);
		evt[b] <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		CLK_I = 1'b0;
		forever #4 CLK_I = ~CLK_I;
	end
	always @(negedge CLK_I)
		if (LB_WE_O === 1'b1)
		begin
			lb_cnt++;
			lb_last = LB_WDATA_O;
		end
	initial
	begin
		repeat (20000) @(posedge CLK_I);
		n_mismatch++;
		$display("CHECK FAILED at %0t: timeout", $time);
		results();
	end
	// ==========================================
	// tests
	initial
	begin
		{RSTN_I, AVS_READ_I, AVS_WRITE_I, push_en, pop_en, slow} = 6'h0;
		{AVS_ADDRESS_I, AVS_WRITEDATA_I, evt} = 35'h0;
		modes = '{`MODE_CAP422, `MODE_CAP420, `MODE_DSP422, `MODE_DSP420};
		void'($urandom(32'h5b30fd35));
		repeat (16) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		repeat (3) @(posedge CLK_I);
		rc(`R_LB_STAT, 16'h0001);
		rc(16'h0002, 16'h0000);
		wr(`R_FIFO_PORT, 16'h1234);
		wr(`R_FIFO_PORT, 16'h5678);
		rc(`R_FIFO_CNT, 16'h0000);
		foreach (modes[i])
		begin
			wr(`R_MOD_CTRL, 16'h0081 | 16'({modes[i], 1'b0}));
			@(negedge CLK_I);
			chk(32'(YUV420_O), 32'(modes[i][2]));
			chk(32'(MOD_EN_O), 32'h1);
		end
		$display("test modes done");
		n = $urandom_range(20, 4);
		slow <= 1'($urandom);
		wr(`R_MOD_CTRL, 16'h0081);
		wr(`R_OP_SEL, 16'h0004);
		wr(`R_CODEC_CTRL, 16'h0080);
		wr(`R_FIFO_SIZE, 16'h0000);
		wr(`R_FSZ_LO, 16'(n * 4));
		wr(`R_FSZ_HI, 16'h0000);
		wr(`R_FIFO_CTRL, 16'h0004);
		wr(`R_MOD_STAT, 16'hFFFF);
		wr(`R_INT_CTRL, 16'h0030);
		wr(`R_CODEC_CTRL, 16'h0001);
		@(negedge CLK_I);
		chk(32'({RUN_O, DECODE_O}), 32'h3);
		for (int i = 0; i < n; i++)
		begin
			exp_q.push_back($urandom);
			wr(`R_FIFO_PORT, exp_q[i][15:0]);
			wr(`R_FIFO_PORT, exp_q[i][31:16]);
		end
		rc(`R_FIFO_CNT, 16'(n));
		rd(`R_MOD_STAT, v);
		chk(32'(v[`S_DEC_DONE]), 32'h1);
		pulse(1);
		pop_en <= 1'b1;
		@(negedge CLK_I);
		chk(32'(HALT_O), 32'h1);
		repeat (20) @(posedge CLK_I);
		chk(32'(u_jhf_codec_model.got.size()), 32'h0);
		wr(`R_MOD_STAT, 16'h0010);
		wr(`R_INT_CTRL, 16'h0020);
		t = 0;
		while (u_jhf_codec_model.got.size() < n && t++ < 500) @(negedge CLK_I);
		foreach (exp_q[i]) chk(u_jhf_codec_model.got[i], exp_q[i]);
		rd(`R_MOD_STAT, v);
		chk(32'({v[`S_DEC_DONE], v[`S_EMPTY], v[`S_MARKER]}), 32'h6);
		pulse(0);
		pop_en <= 1'b0;
		@(negedge CLK_I);
		chk(32'(RUN_O), 32'h0);
		rc(`R_OP_STAT, 16'h0000);
		wr(`R_FIFO_PORT, 16'h0BAD);
		wr(`R_FIFO_PORT, 16'h0BAD);
		rc(`R_FIFO_CNT, 16'h0000);
		$display("test decode done");
		thr = $urandom_range(3, 0);
		p = $urandom_range(1100, 100);
		slow <= 1'b0;
		wr(`R_OP_SEL, 16'h0000);
		wr(`R_MOD_CTRL, 16'h0087);
		wr(`R_FIFO_CTRL, 16'(thr << 4) | 16'h0004);
		wr(`R_CODEC_CTRL, 16'h0001);
		wr(`R_MOD_STAT, 16'hFFFF);
		wr(`R_CAP_CTRL, 16'h0001);
		@(negedge CLK_I);
		chk(32'(CAP_RUN_O), 32'h1);
		@(posedge CLK_I);
		push_en <= 1'b1;
		repeat (p) @(posedge CLK_I);
		push_en <= 1'b0;
		repeat (4) @(posedge CLK_I);
		chk(32'(na), 32'(p < CAP ? p : CAP));
		rc(`R_FIFO_CNT, 16'(na));
		rd(`R_MOD_STAT, v);
		chk(32'({v[`S_FULL], v[`S_THR]}),
			32'({na == CAP, na >= (CAP >> (3 - thr))}));
		for (int i = 0; i < 4; i++)
		begin
			rd(`R_FIFO_PORT, lo);
			rd(`R_FIFO_PORT, hi);
			chk({hi, lo}, 32'hA5000000 + 32'(i));
		end
		wr(`R_CAP_CTRL, 16'h0000);
		wr(`R_FIFO_CTRL, 16'h0004);
		rc(`R_FIFO_CNT, 16'h0000);
		chk(32'(RUN_O), 32'h0);
		$display("test capture done");
		lb_cnt = 0;
		d = 16'($urandom);
		wr(`R_MOD_CTRL, 16'h0083);
		wr(`R_LB_CTRL, 16'h0001);
		wr(`R_LB_PORT, d);
		repeat (2) @(negedge CLK_I);
		chk(32'({lb_cnt[15:0], lb_last}), {16'h1, d});
		wr(`R_LB_STAT, 16'h0001);
		rc(`R_LB_STAT, 16'h0000);
		wr(`R_LB_PORT, ~d);
		repeat (2) @(negedge CLK_I);
		chk(32'(lb_cnt), 32'h1);
		pulse(2);
		wr(`R_LB_STAT, 16'h0000);
		rc(`R_LB_STAT, 16'h0001);
		$display("test line buffer done");
		wr(`R_INT_CTRL, 16'h0000);
		wr(`R_MOD_STAT, 16'hFFFF);
		wr(`R_OP_SEL, 16'h0000);
		wr(`R_MOD_CTRL, 16'h0080);
		wr(`R_MOD_CTRL, 16'h0000);
		@(negedge CLK_I);
		chk(32'({MOD_EN_O, DECODE_O, RUN_O}), 32'h0);
		rc(`R_INT_CTRL, 16'h0000);
		$display("test exit done");
		results();
	end
endmodule // jpeg_host_fifo_control_tb
`default_nettype wire
